// ==== logic/pwm_map.svh ====
// Register offsets, field positions, reset values and rule summary for the four-channel PWM.
// Summary of operation
// R1 - After reset every channel output sits at the level chosen by reset_level_select.
// R2 - One shared 10-bit down counter clocked every CPU clock serves all channels.
// R3 - On underflow the counter reloads from the holding register; period is value plus one.
// R4 - period_value is high-byte bits 1:0 above all of the low byte.
// R5 - Run, load and underflow flag set copy period to holding; load self-clears next clock.
// R6 - Underflow sets the flag; only software clears it.
// R7 - A channel drives low while its compare exceeds the counter, high otherwise.
// R8 - New compare values move to active registers at underflow only when load is set.
// R9 - High time per period is period minus compare plus one counter clocks.
// R10 - Compare 000h keeps output high; 3FFh keeps it low.
// R11 - Brake may come from a software bit or the external brake pin.
// R12 - Brake pin is active low with polarity bit clear, active high when set.
// R13 - An asserted brake pin clears counter_run and sets brake_flag.
// R14 - brake_flag is readable and raises the brake request when enabled.
// R15 - When brake ends, outputs return to the level held just before brake.
// R16 - The brake pin is synchronised to the CPU clock before use.
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CONTROL_ONE   8'h00
`define ADDR_CONTROL_TWO   8'h04
`define ADDR_CONTROL_THREE 8'h08
`define ADDR_PERIOD_LOW    8'h0c
`define ADDR_PERIOD_HIGH   8'h10
`define ADDR_COMPARE_BASE  8'h20
`define ADDR_COUNTER       8'h30
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BIT_RUN            7
`define BIT_LOAD           6
`define BIT_UNDERFLOW      5
`define BIT_SW_BRAKE       0
`define BIT_BRAKE_POL      6
`define BIT_BRAKE_IRQ_EN   1
`define BIT_BRAKE_FLAG     0
`define CMP_ALL_LOW        10'h3ff
`define PERIOD_RESET       10'h3ff
`endif

// ==== logic/pwm_pkg.sv ====
// Types shared by the PWM design modules.
`default_nettype none
package pwm_pkg;
    typedef logic [9:0] count_t;
    typedef enum logic [1:0] {
        RUN_IDLE  = 2'b00,
        RUN_COUNT = 2'b01,
        RUN_BRAKE = 2'b10
    } run_state_t;
endpackage : pwm_pkg
`default_nettype wire

// ==== logic/pwm_timebase_if.sv ====
// Interface carrying the shared timebase between counter and channel compare.
`timescale 1ns/1ps
`default_nettype none
interface pwm_timebase_if;
    pwm_pkg::count_t count;
    logic            underflow;
    logic            hold;
    logic            load;
    modport source (output count, output underflow, output hold, input load);
    modport sink   (input count, input underflow, input hold, input load);
endinterface : pwm_timebase_if
`default_nettype wire

// ==== logic/pwm_channel.sv ====
// One PWM channel: double-buffered compare and output stage.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_map.svh"
module pwm_channel (
    // Clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      reset_level_i,
    // Timebase and staged compare
    pwm_timebase_if.sink   tb,
    input  wire logic [9:0] staged_i,
    // Output
    output logic           out_o
);
    pwm_pkg::count_t active;
    // 3FFh is decoded apart so it stays low even when the period itself is 3FFh.
    wire             next_level = (active != `CMP_ALL_LOW) && !(active > tb.count); // R7 R9 R10
    // ----------------------------------------
    // Compare transfer and output register
    // ----------------------------------------
    // Held outputs freeze during brake so the pre-brake level returns afterwards.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active <= `CMP_ALL_LOW;
            out_o  <= reset_level_i; // R1
        end else begin
            if (tb.underflow && tb.load) begin
                active <= staged_i; // R8
            end
            if (!tb.hold) begin
                out_o <= next_level; // R15
            end
        end
    end
    // Reset level is a plain selection on the first cycles after reset.
    logic started;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            started <= 1'b0;
        end else if (!tb.hold) begin
            started <= 1'b1;
        end
    end
    a_hold_freezes: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        started && tb.hold |=> $stable(out_o)) else $error("Output moved during hold.");
    a_full_low: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        active == `CMP_ALL_LOW && !tb.hold |=> !out_o) else $error("Full compare let the output rise.");
endmodule : pwm_channel
`default_nettype wire

// ==== logic/pwm_top.sv ====
// Four-channel 10-bit PWM with brake, Wishbone register slave.
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_map.svh"
module pwm_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        reset_level_select_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Brake pin
    input  wire logic        brake_pin_i,
    // Outputs
    output logic             channel_out_zero_o,
    output logic             channel_out_one_o,
    output logic             channel_out_two_o,
    output logic             channel_out_three_o,
    output logic             brake_request_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    pwm_timebase_if tb();
    pwm_pkg::count_t  counter;
    pwm_pkg::count_t  holding;
    logic [7:0]       period_low_byte;
    logic [1:0]       period_high_byte;
    logic [9:0]       channel_compare [4];
    logic             counter_run;
    logic             load;
    logic             underflow_flag;
    logic             sw_brake;
    logic             brake_polarity_select;
    logic             brake_irq_en;
    logic             brake_flag;
    logic [2:0]       pin_sync;
    logic             pin_level;
    logic             rst_level;
    logic             out_valid;
    logic [3:0]       chan_raw;

    wire [9:0] period_value = {period_high_byte, period_low_byte}; // R4
    wire pin_brake    = brake_polarity_select ? pin_level : !pin_level; // R12
    wire brake_active = sw_brake || pin_brake; // R11
    wire underflow    = counter_run && !brake_active && (counter == 10'h000);
    // A write lands at the edge where ack is seen high, while the master still holds its request.
    wire wr_stb       = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    wire rd_stb       = cyc_i && stb_i && !ack_o;

    function automatic logic hit(input logic [7:0] a);
        hit = (adr_i == a);
    endfunction : hit

    assign tb.count     = counter;
    assign tb.underflow = underflow;
    // Outputs also freeze while the counter is stopped, so they resume exactly where braking left them.
    assign tb.hold      = brake_active || !counter_run || !out_valid; // R15
    assign tb.load      = load;

    // ----------------------------------------
    // Synchroniser and reset-level capture
    // ----------------------------------------
    // The pin stages carry no reset, so they hold the pin's real level when reset lifts and no
    // false brake follows reset; a change counts once the second and third stages agree.
    always_ff @(posedge clk_i) begin
        pin_sync <= {pin_sync[1:0], brake_pin_i}; // R16
        if (pin_sync[2] == pin_sync[1]) begin
            pin_level <= pin_sync[2]; // R16
        end
    end

    // The reset level is sampled every clock once reset lifts.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_level <= 1'b0;
        end else begin
            rst_level <= reset_level_select_i;
        end
    end

    // ----------------------------------------
    // Counter, run and load control
    // ----------------------------------------
    // Counter runs on every clock; the CPU clock is the PWM clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter   <= `PERIOD_RESET;
            holding   <= `PERIOD_RESET;
            out_valid <= 1'b0;
        end else begin
            if (counter_run && !brake_active) begin
                out_valid <= 1'b1;
                if (underflow) begin
                    counter <= (load && underflow_flag) ? period_value : holding; // R3 R5
                    if (load && underflow_flag) begin
                        holding <= period_value; // R5
                    end
                end else begin
                    counter <= counter - 10'h001; // R2
                end
            end
        end
    end

    // ----------------------------------------
    // Register writes and flags
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_low_byte       <= 8'(`PERIOD_RESET);
            period_high_byte      <= 2'(`PERIOD_RESET >> 8);
            counter_run           <= 1'b0;
            load                  <= 1'b0;
            underflow_flag        <= 1'b0;
            sw_brake              <= 1'b0;
            brake_polarity_select <= 1'b0;
            brake_irq_en          <= 1'b0;
            brake_flag            <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                channel_compare[i] <= `CMP_ALL_LOW;
            end
        end else begin
            if (wr_stb && hit(`ADDR_CONTROL_ONE)) begin
                counter_run    <= dat_i[`BIT_RUN];
                load           <= dat_i[`BIT_LOAD];
                underflow_flag <= underflow_flag & dat_i[`BIT_UNDERFLOW];
            end
            if (wr_stb && hit(`ADDR_CONTROL_TWO)) begin
                sw_brake              <= dat_i[`BIT_SW_BRAKE];
                brake_polarity_select <= dat_i[`BIT_BRAKE_POL];
            end
            if (wr_stb && hit(`ADDR_CONTROL_THREE)) begin
                brake_irq_en <= dat_i[`BIT_BRAKE_IRQ_EN];
                brake_flag   <= brake_flag & dat_i[`BIT_BRAKE_FLAG];
            end
            if (wr_stb && hit(`ADDR_PERIOD_LOW)) begin
                period_low_byte <= dat_i[7:0];
            end
            if (wr_stb && hit(`ADDR_PERIOD_HIGH)) begin
                period_high_byte <= dat_i[1:0];
            end
            for (int i = 0; i < 4; i++) begin
                if (wr_stb && hit(`ADDR_COMPARE_BASE + 8'(4 * i))) begin
                    channel_compare[i] <= {sel_i[1] ? dat_i[9:8] : channel_compare[i][9:8], dat_i[7:0]};
                end
            end
            // Hardware sets win over software clears in the same cycle.
            if (underflow) begin
                underflow_flag <= 1'b1; // R6
            end
            if (underflow && load && underflow_flag) begin
                load <= 1'b0; // R5
            end
            if (pin_brake) begin
                counter_run <= 1'b0; // R13
                brake_flag  <= 1'b1; // R13
            end
        end
    end

    // ----------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------
    logic [31:0] next_rd;
    always_comb begin
        next_rd = 32'h0;
        if (hit(`ADDR_CONTROL_ONE)) next_rd[7:5] = {counter_run, load, underflow_flag};
        if (hit(`ADDR_CONTROL_TWO)) next_rd[7:0] = {1'b0, brake_polarity_select, 5'h0, sw_brake};
        if (hit(`ADDR_CONTROL_THREE)) next_rd[1:0] = {brake_irq_en, brake_flag}; // R14
        if (hit(`ADDR_PERIOD_LOW)) next_rd[7:0] = period_low_byte;
        if (hit(`ADDR_PERIOD_HIGH)) next_rd[1:0] = period_high_byte;
        if (hit(`ADDR_COUNTER)) next_rd[9:0] = counter;
        for (int i = 0; i < 4; i++) begin
            if (hit(`ADDR_COMPARE_BASE + 8'(4 * i))) next_rd[9:0] = channel_compare[i];
        end
    end

    // Single-cycle answer; unmapped addresses ack and read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= rd_stb;
            dat_o <= rd_stb ? next_rd : 32'h0;
        end
    end

    assign brake_request_o = brake_flag && brake_irq_en; // R14

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_chan
        pwm_channel u_chan (
            .clk_i         (clk_i),
            .rst_i         (rst_i),
            .reset_level_i (rst_level),
            .tb            (tb),
            .staged_i      (channel_compare[g]),
            .out_o         (chan_raw[g])
        );
    end

    // Before the first run the reset level stands on all outputs.
    wire [3:0] chan_out = out_valid ? chan_raw : {4{rst_level}}; // R1
    assign channel_out_zero_o  = chan_out[0];
    assign channel_out_one_o   = chan_out[1];
    assign channel_out_two_o   = chan_out[2];
    assign channel_out_three_o = chan_out[3];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        $past(underflow) |-> underflow_flag) else $error("Underflow flag not set.");
    // Only a software write of zero may take the underflow flag down.
    a_flag_kept: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        underflow_flag && !(wr_stb && hit(`ADDR_CONTROL_ONE) && !dat_i[`BIT_UNDERFLOW]) |=> underflow_flag)
        else $error("Underflow flag lost.");
    a_pin_stops_run: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        pin_brake |=> !counter_run && brake_flag) else $error("Brake pin did not stop.");
    a_load_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        underflow && load && underflow_flag && !(wr_stb && hit(`ADDR_CONTROL_ONE)) |=> !load
        && counter == $past(period_value)) else $error("Load did not self-clear.");
    a_count_down: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        counter_run && !brake_active && counter != 10'h0 |=> counter == $past(counter) - 10'h001)
        else $error("Counter did not decrement.");
    a_reload: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        underflow && !(load && underflow_flag) |=> counter == $past(holding)) else $error("No reload.");
    a_brake_req: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        brake_flag && brake_irq_en |-> brake_request_o) else $error("Brake request missing.");
    // The pins must follow the strap input sampled one clock earlier until the first run.
    a_reset_level: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        !out_valid && !$past(rst_i) |-> chan_out == {4{$past(reset_level_select_i)}})
        else $error("Reset level wrong.");
    a_brake_stops: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        brake_active |=> $stable(counter)) else $error("Counter moved in brake.");
    a_period_write: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        wr_stb && hit(`ADDR_PERIOD_LOW) |=> period_low_byte == $past(dat_i[7:0]))
        else $error("Period write lost.");
endmodule : pwm_top
`default_nettype wire

// ==== bench/pwm_load_model.sv ====
// Load model that watches the four channel outputs and measures their waveforms.
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
    // Clock
    input  wire logic             clk_i,
    // Channel outputs and measurement window
    input  wire logic [3:0]       out_i,
    input  wire logic             win_i,
    // Measurements
    output logic      [3:0][15:0] high_o,
    output logic      [15:0]      period_o,
    output logic      [15:0]      toggles_o
);
    logic [3:0]  prev  = 4'h0;
    logic        win_d = 1'b0;
    logic [15:0] cnt   = 16'h0000;
    logic [15:0] tog   = 16'h0000;

    assign toggles_o = tog;

    // The load sees only pin levels; it counts high cycles in a window and edge spacing on channel two.
    always @(posedge clk_i) begin
        prev  <= out_i;
        win_d <= win_i;
        cnt   <= cnt + 16'h0001;
        for (int i = 0; i < 4; i++) begin
            if (win_i && !win_d) begin
                high_o[i] <= {15'h0000, out_i[i]};
            end else if (win_i) begin
                high_o[i] <= high_o[i] + {15'h0000, out_i[i]};
            end
        end
        if (out_i[2] && !prev[2]) begin
            period_o <= cnt;
            cnt      <= 16'h0001;
        end
        if (out_i[2] != prev[2]) begin
            tog <= tog + 16'h0001;
        end
    end
endmodule : pwm_load_model
`default_nettype wire

// ==== bench/tb_four_channel_pwm_with_brake.sv ====
// Self-checking testbench for the four-channel PWM with brake.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_map.svh"
module tb_four_channel_pwm_with_brake;
    logic clk_i = 1'b0, rst_i = 1'b1, lvl = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic ack_o, brake_pin_i = 1'b1, brake_request_o, win = 1'b0;
    logic [3:0] outs, snap;
    logic [3:0][15:0] high;
    logic [15:0] period, toggles, tog0;
    int n_errors = 0, checks = 0, cycles = 0;
    // Period 0x102 gives 259 cycles; compares cover both fixed levels and two duty cycles.
    localparam logic [9:0] P = 10'h102;
    logic [3:0][9:0] cmp = {10'h102, 10'h040, 10'h3ff, 10'h000};

    always #2 clk_i = ~clk_i;

    pwm_top uut (.clk_i(clk_i), .rst_i(rst_i), .reset_level_select_i(lvl), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .brake_pin_i(brake_pin_i), .channel_out_zero_o(outs[0]), .channel_out_one_o(outs[1]),
        .channel_out_two_o(outs[2]), .channel_out_three_o(outs[3]), .brake_request_o(brake_request_o));
    pwm_load_model load (.clk_i(clk_i), .out_i(outs), .win_i(win), .high_o(high), .period_o(period),
        .toggles_o(toggles));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // A hang here would mask every later check, so the cycle ceiling ends the run instead.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic cycle: hold everything until ack is sampled, then release and idle one cycle.
    task automatic wb(input int w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= (w != 0);
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic do_reset(input logic level);
        rst_i <= 1'b1;
        lvl   <= level;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(outs, {4{level}});
    endtask : do_reset

    task automatic measure();
        win <= 1'b1;
        repeat (259) @(posedge clk_i);
        win <= 1'b0;
        @(posedge clk_i);
    endtask : measure

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        @(posedge clk_i);
        do_reset(1'b0);
        do_reset(1'b1);
        // Upper bits of the high byte must be ignored by the period.
        wb(1, `ADDR_PERIOD_LOW, 32'h02);
        wb(1, `ADDR_PERIOD_HIGH, 32'hfd);
        for (int i = 0; i < 4; i++) wb(1, `ADDR_COMPARE_BASE + 8'(4 * i), {22'h0, cmp[i]});
        wb(1, `ADDR_CONTROL_ONE, 32'hc0);
        for (int n = 0; n < 2000; n++) begin
            wb(0, `ADDR_CONTROL_ONE, 32'h0);
            if (q[`BIT_LOAD] === 1'b0) break;
        end
        chk(q[`BIT_LOAD], 1'b0);
        chk(q[`BIT_UNDERFLOW], 1'b1);
        repeat (600) @(posedge clk_i);
        measure();
        for (int i = 0; i < 4; i++) chk(high[i], (cmp[i] > P) ? 16'h0 : 16'(P - cmp[i] + 10'h1));
        chk(period, 16'(P) + 16'h1);
        wb(0, `ADDR_COUNTER, 32'h0);
        chk(q <= 32'(P), 1'b1);
        // A compare written without load must not reach channel zero, which stays high.
        wb(1, `ADDR_COMPARE_BASE, 32'h3ff);
        repeat (600) @(posedge clk_i);
        chk(outs[0], 1'b1);
        // Software brake freezes the outputs, and releasing it lets them move again.
        wb(1, `ADDR_CONTROL_TWO, 32'h01);
        repeat (2) @(posedge clk_i);
        tog0 = toggles;
        repeat (300) @(posedge clk_i);
        chk(toggles, tog0);
        wb(1, `ADDR_CONTROL_TWO, 32'h00);
        repeat (600) @(posedge clk_i);
        chk(toggles != tog0, 1'b1);
        // Pin brake, active low while the polarity bit is clear; the synchroniser delays it.
        wb(1, `ADDR_CONTROL_THREE, 32'h02);
        brake_pin_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        snap = outs;
        wb(0, `ADDR_CONTROL_ONE, 32'h0);
        chk(q[`BIT_RUN], 1'b0);
        wb(0, `ADDR_CONTROL_THREE, 32'h0);
        chk(q[`BIT_BRAKE_FLAG], 1'b1);
        chk(brake_request_o, 1'b1);
        brake_pin_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk(outs, snap);
        wb(1, `ADDR_CONTROL_THREE, 32'h02);
        chk(brake_request_o, 1'b0);
        // With the polarity bit set a low pin is idle and a high pin brakes.
        wb(1, `ADDR_CONTROL_TWO, 32'h40);
        brake_pin_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(1, `ADDR_CONTROL_ONE, 32'h80);
        repeat (20) @(posedge clk_i);
        wb(0, `ADDR_CONTROL_ONE, 32'h0);
        chk(q[`BIT_RUN], 1'b1);
        // The polarity change over braked once; drop that flag so the next check needs a fresh set.
        wb(1, `ADDR_CONTROL_THREE, 32'h02);
        chk(brake_request_o, 1'b0);
        brake_pin_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wb(0, `ADDR_CONTROL_ONE, 32'h0);
        chk(q[`BIT_RUN], 1'b0);
        wb(0, `ADDR_CONTROL_THREE, 32'h0);
        chk(q[`BIT_BRAKE_FLAG], 1'b1);
        wb(0, 8'hfc, 32'h0);
        chk(q, 32'h0);
        results();
    end
endmodule : tb_four_channel_pwm_with_brake
`default_nettype wire
